// ### verilog/gate_ctrl_pkg.sv
package gate_ctrl_pkg;

  // Clock period of the controller in picoseconds (100 MHz).
  localparam int unsigned CLK_PERIOD_PS = 10000;

  // Deglitch width of the driver's inputs, in nanoseconds.
  localparam int unsigned DEGLITCH_NS = 40;

  // Minimum width of a host pulse so the driver never filters it, in clock cycles.
  localparam int unsigned DEGLITCH_CYC = (DEGLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;

  // Default fault mute time in nanoseconds.
  localparam int unsigned FAULT_MUTE_NS = 1000;

  // Default fault mute time in clock cycles, rounded up.
  localparam int unsigned FAULT_MUTE_CYC = (FAULT_MUTE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Default reset filter time in nanoseconds.
  localparam int unsigned RESET_FILTER_NS = 1000;

  // Default reset filter time in clock cycles, rounded up, plus margin.
  localparam int unsigned RESET_FILTER_CYC =
    (RESET_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 2;

  // Width of every timer in the controller.
  localparam int unsigned TIMER_W = 16;

  // Width of the sense PWM period and high-time counters.
  localparam int unsigned SENSE_W = 16;

  // Lowest and highest legal sense duty in percent.
  localparam int unsigned DUTY_MIN_PCT = 10;
  localparam int unsigned DUTY_MAX_PCT = 88;

  // Reset value of the timer fields.
  localparam logic [15:0] TIMER_RESET = 16'h0000;

  // States of the enable and fault recovery sequencer.
  typedef enum logic [4:0] {
    ST_OFF     = 5'b0_0001,
    ST_RUN     = 5'b0_0010,
    ST_MUTE    = 5'b0_0100,
    ST_CLEAR   = 5'b0_1000,
    ST_RELEASE = 5'b1_0000
  } seq_state_e;

endpackage : gate_ctrl_pkg

// ### verilog/sense_pwm_meter.sv
`timescale 1ns/1ps
`default_nettype none

// Measures the period and high time of the sense PWM pin, one result per period.
module sense_pwm_meter (
  input  wire logic                               clk,
  input  wire logic                               rst_n,
  input  wire logic                               pwm_sync,
  output var  logic [gate_ctrl_pkg::SENSE_W-1:0]  period_reg,
  output var  logic [gate_ctrl_pkg::SENSE_W-1:0]  high_reg,
  output var  logic                               valid_reg
);

  // All state of the meter in one record.
  typedef struct packed {
    logic                              prev;
    logic [gate_ctrl_pkg::SENSE_W-1:0] per_cnt;
    logic [gate_ctrl_pkg::SENSE_W-1:0] hi_cnt;
    logic [gate_ctrl_pkg::SENSE_W-1:0] period;
    logic [gate_ctrl_pkg::SENSE_W-1:0] high;
    logic                              valid;
  } meter_s;

  meter_s st_reg;   // Registered state.
  meter_s st_next;  // Next state.

  // Counters saturate so a stuck pin never wraps into a plausible reading.
  always_comb begin
    st_next       = st_reg;
    st_next.prev  = pwm_sync;
    st_next.valid = 1'b0;
    if (pwm_sync && !st_reg.prev) begin
      // A rising edge closes one period and starts the next.
      st_next.period  = st_reg.per_cnt;
      st_next.high    = st_reg.hi_cnt;
      st_next.valid   = 1'b1;
      st_next.per_cnt = 16'h0001;
      st_next.hi_cnt  = 16'h0001;
    end else begin
      if (st_reg.per_cnt != 16'hFFFF) begin
        st_next.per_cnt = st_reg.per_cnt + 16'h0001;
      end
      if (pwm_sync && st_reg.hi_cnt != 16'hFFFF) begin
        st_next.hi_cnt = st_reg.hi_cnt + 16'h0001;
      end
    end
  end

  // State register with asynchronous reset to constants.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign period_reg = st_reg.period;
  assign high_reg   = st_reg.high;
  assign valid_reg  = st_reg.valid;

endmodule : sense_pwm_meter

`default_nettype wire

// ### verilog/gate_driver_host.sv
// Overview of operation
// - Host holds enable low past mute plus filter
// - Host never floats inputs; unused inverting grounded
// - Inverting PWM auto-reset uses inverted enable
// - Auto-reset PWM off-time exceeds reset filter
`timescale 1ns/1ps
`default_nettype none

module gate_driver_host #(
  parameter logic [15:0] FAULT_MUTE_CYC   = 16'(gate_ctrl_pkg::FAULT_MUTE_CYC),
  parameter logic [15:0] RESET_FILTER_CYC = 16'(gate_ctrl_pkg::RESET_FILTER_CYC)
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  // User side.
  input  wire logic        run_req,
  input  wire logic        pwm_cmd,
  input  wire logic        pwm_low_cmd,
  input  wire logic        auto_reset_mode,
  input  wire logic        invert_mode,
  input  wire logic        fault_clear_req,
  output var  logic        running,
  output var  logic        fault_seen,
  output var  logic        supply_good,
  output var  logic [15:0] sense_period,
  output var  logic [15:0] sense_high,
  output var  logic        sense_valid,
  // Driver pins.
  output var  logic        pwm_noninv_pin,
  output var  logic        pwm_inv_pin,
  output var  logic        enable_pin,
  input  wire logic        fault_flag_n,
  input  wire logic        supply_good_pin,
  input  wire logic        sense_pwm_out
);

  // Reset synchroniser: asynchronous assert, release after two edges.
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Pin synchronisers; the first stage feeds only the second.
  logic [2:0] pin_s1_reg;
  logic [2:0] pin_s2_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= 3'b011;
      pin_s2_reg <= 3'b011;
    end else begin
      pin_s1_reg <= {sense_pwm_out, supply_good_pin, fault_flag_n};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // Sense PWM decoding lives in its own module.
  sense_pwm_meter u_meter (
    .clk        (clk),
    .rst_n      (rst_n),
    .pwm_sync   (pin_s2_reg[2]),
    .period_reg (sense_period),
    .high_reg   (sense_high),
    .valid_reg  (sense_valid)
  );

  // Whole controller state.
  typedef struct packed {
    gate_ctrl_pkg::seq_state_e state;
    logic [15:0]               timer;
    logic [15:0]               hold;
    logic                      noninv;
    logic                      inv;
    logic                      en;
    logic                      running;
    logic                      fault_seen;
    logic                      supply_good;
  } ctrl_s;

  ctrl_s st_reg;   // Registered state.
  ctrl_s st_next;  // Next state.

  // Pin levels as seen after synchronisation.
  logic fault_active;
  logic supply_ok;
  assign fault_active = !pin_s2_reg[0];
  assign supply_ok    = pin_s2_reg[1];

  // Saturating increment used by both timers.
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction : sat_inc

  // Sequencer: commanded gate input changes are held at least one deglitch width
  // so the driver never filters a level the host meant; a fault drops all pins at once, a stop drops enable at once and the gate inputs a cycle later.
  always_comb begin
    logic want_on;
    logic want_inv;
    want_on  = 1'b0;
    want_inv = 1'b0;
    st_next             = st_reg;
    st_next.timer       = sat_inc(st_reg.timer);
    st_next.hold        = sat_inc(st_reg.hold);
    st_next.supply_good = supply_ok;
    // The inverting input takes the inverted command in invert mode, else pwm_low_cmd.
    want_on  = invert_mode ? 1'b0 : pwm_cmd;
    want_inv = invert_mode ? !pwm_cmd : pwm_low_cmd;
    case (st_reg.state)
      gate_ctrl_pkg::ST_OFF: begin
        st_next.en      = 1'b0;
        st_next.noninv  = 1'b0;
        st_next.inv     = 1'b0;
        st_next.running = 1'b0;
        if (run_req && st_reg.timer >= 16'(gate_ctrl_pkg::DEGLITCH_CYC)) begin
          st_next.state = gate_ctrl_pkg::ST_RUN;
          st_next.timer = gate_ctrl_pkg::TIMER_RESET;
        end
      end
      gate_ctrl_pkg::ST_RUN: begin
        st_next.running = 1'b1;
        if (st_reg.hold >= 16'(gate_ctrl_pkg::DEGLITCH_CYC)) begin
          st_next.noninv = invert_mode ? 1'b1 : want_on;
          st_next.inv    = want_inv;
          if ((invert_mode ? 1'b1 : want_on) != st_reg.noninv || want_inv != st_reg.inv) begin
            st_next.hold = gate_ctrl_pkg::TIMER_RESET;
          end
        end
        // Automatic reset: enable follows the effective gate command.
        if (auto_reset_mode) begin
          st_next.en = invert_mode ? !st_reg.inv : st_reg.noninv;
        end else begin
          st_next.en = 1'b1;
        end
        if (fault_active) begin
          st_next.state      = gate_ctrl_pkg::ST_MUTE;
          st_next.fault_seen = 1'b1;
          st_next.timer      = gate_ctrl_pkg::TIMER_RESET;
          // Drop the enable at once, so the mute window opens with it already low.
          st_next.en         = 1'b0;
          st_next.noninv     = 1'b0;
          st_next.inv        = 1'b0;
          st_next.running    = 1'b0;
        end else if (!run_req) begin
          st_next.state = gate_ctrl_pkg::ST_OFF;
          st_next.timer = gate_ctrl_pkg::TIMER_RESET;
          st_next.en    = 1'b0;
        end
      end
      gate_ctrl_pkg::ST_MUTE: begin
        // The driver ignores the enable line here, so drive it low early.
        st_next.en = 1'b0;
        if (st_reg.timer >= FAULT_MUTE_CYC) begin
          st_next.state = gate_ctrl_pkg::ST_CLEAR;
          st_next.timer = gate_ctrl_pkg::TIMER_RESET;
        end
      end
      gate_ctrl_pkg::ST_CLEAR: begin
        st_next.en = 1'b0;
        if (st_reg.timer >= RESET_FILTER_CYC && (fault_clear_req || auto_reset_mode)) begin
          st_next.state = gate_ctrl_pkg::ST_RELEASE;
          st_next.timer = gate_ctrl_pkg::TIMER_RESET;
          st_next.en    = 1'b1;
        end
      end
      gate_ctrl_pkg::ST_RELEASE: begin
        st_next.en = 1'b1;
        if (!fault_active && st_reg.timer >= 16'(gate_ctrl_pkg::DEGLITCH_CYC)) begin
          st_next.state      = run_req ? gate_ctrl_pkg::ST_RUN : gate_ctrl_pkg::ST_OFF;
          st_next.en         = run_req;
          st_next.timer      = gate_ctrl_pkg::TIMER_RESET;
          st_next.hold       = gate_ctrl_pkg::TIMER_RESET;
          st_next.fault_seen = fault_active;
        end else if (st_reg.timer >= RESET_FILTER_CYC) begin
          // Driver did not release: retry the whole clear.
          st_next.state = gate_ctrl_pkg::ST_CLEAR;
          st_next.timer = gate_ctrl_pkg::TIMER_RESET;
          st_next.en    = 1'b0;
        end
      end
      default: begin
        st_next.state = gate_ctrl_pkg::ST_OFF;
        st_next.en    = 1'b0;
      end
    endcase
    // A new fault while clearing is reported again; set wins.
    if (fault_active && st_reg.state != gate_ctrl_pkg::ST_RELEASE) begin
      st_next.fault_seen = 1'b1;
    end
    // Outside invert mode never command both inputs high; the driver would block the gate anyway.
    if (st_next.noninv && st_next.inv && !invert_mode) begin
      st_next.noninv = 1'b0;
    end
  end

  // State register; reset to the disabled state.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{state: gate_ctrl_pkg::ST_OFF, timer: gate_ctrl_pkg::TIMER_RESET,
                  hold: gate_ctrl_pkg::TIMER_RESET, default: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register.
  assign pwm_noninv_pin = st_reg.noninv;
  assign pwm_inv_pin    = st_reg.inv;
  assign enable_pin     = st_reg.en;
  assign running        = st_reg.running;
  assign fault_seen     = st_reg.fault_seen;
  assign supply_good    = st_reg.supply_good;

endmodule : gate_driver_host

`default_nettype wire

// ### dv/gate_driver_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural driver device: deglitch, interlock, fault latch, supply flag, sense PWM.
module gate_driver_model #(
  parameter int MUTE = 4,
  parameter int FILT = 3
) (
  input  wire logic       clk,
  input  wire logic       in_p,
  input  wire logic       in_n,
  input  wire logic       en,
  input  wire logic       overcurrent_sense,
  input  wire logic       uvlo,
  input  wire logic [6:0] duty,
  output logic            gate_on,
  output logic            fault_flag_n,
  output logic            supply_good_pin,
  output logic            sense_pwm_out
);
  logic [2:0] raw;
  logic [2:0] filt = 3'h0;
  logic       lat  = 1'b0;
  int         dg[3] = '{0, 0, 0};
  int         on_t = 0;
  int         t    = 0;
  int         lo_t = 0;
  int         p    = 0;
  // An undriven or unknown pin reads as low, as with a pulldown.
  assign raw = {en === 1'b1, in_n === 1'b1, in_p === 1'b1};
  // A level must stand four cycles (40 ns) before it is taken.
  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (raw[i] == filt[i]) dg[i] <= 0;
      else if (dg[i] == 3) begin
        filt[i] <= raw[i];
        dg[i] <= 0;
      end else dg[i] <= dg[i] + 1;
    end
  end
  // Sensing is blanked for 20 cycles after turn-on; mute and filter are counted after.
  always @(posedge clk) begin
    on_t <= gate_on ? on_t + 1 : 0;
    if (!lat) begin
      t <= 0;
      lo_t <= 0;
      if (overcurrent_sense && gate_on && on_t >= 20) lat <= 1'b1;
    end else begin
      t <= t + 1;
      if (t < MUTE) lo_t <= 0;
      else if (!filt[2]) lo_t <= lo_t + 1;
      else begin
        lo_t <= 0;
        if (lo_t >= FILT) lat <= 1'b0;
      end
    end
    p <= (p == 99) ? 0 : p + 1;
  end
  // The soft ramp is analog; here the drive simply drops at once.
  assign gate_on = filt[2] && filt[0] && !filt[1] && !lat && !uvlo;
  // Both flags only pull low; released they sit at the pull-up level.
  assign fault_flag_n = !lat;
  assign supply_good_pin = !uvlo;
  assign sense_pwm_out = p < duty;
endmodule : gate_driver_model
`default_nettype wire

// ### dv/gate_driver_host_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the controller's pins against the driver protocol.
module gate_driver_host_chk #(
  parameter logic [15:0] FAULT_MUTE_CYC   = 16'h0004,
  parameter logic [15:0] RESET_FILTER_CYC = 16'h0006
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic invert_mode,
  input wire logic pwm_noninv_pin,
  input wire logic pwm_inv_pin,
  input wire logic enable_pin,
  input wire logic fault_flag_n,
  input wire logic fault_seen,
  input wire logic running,
  input wire logic supply_good_pin,
  input wire logic supply_good
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // A fault is the flag dropping, then the sequencer muting the enable line.
  sequence s_drop; $fell(fault_flag_n); endsequence
  sequence s_muted; fault_seen && !enable_pin; endsequence
  property p_lock; !invert_mode |-> !(pwm_noninv_pin && pwm_inv_pin); endproperty
  a_lock: assert property (p_lock) else $error("both inputs high");
  property p_fault; s_drop |-> ##[1:8] s_muted; endproperty
  a_fault: assert property (p_fault) else $error("fault not answered");
  property p_mute; $rose(fault_seen) |-> !enable_pin [*8]; endproperty
  a_mute: assert property (p_mute) else $error("enable raised early");
  property p_hold; !fault_flag_n [*6] |-> !running; endproperty
  a_hold: assert property (p_hold) else $error("running while latched");
  property p_uv; $fell(supply_good_pin) |-> ##[1:4] !supply_good; endproperty
  a_uv: assert property (p_uv) else $error("supply loss missed");
  property p_ok; $rose(supply_good_pin) |-> ##[1:4] supply_good; endproperty
  a_ok: assert property (p_ok) else $error("supply return missed");
  property p_gn; $changed(pwm_noninv_pin) |=> $stable(pwm_noninv_pin) [*5]; endproperty
  a_gn: assert property (p_gn) else $error("input pulse too short");
  property p_gi; $changed(pwm_inv_pin) |=> $stable(pwm_inv_pin) [*5]; endproperty
  a_gi: assert property (p_gi) else $error("inverting pulse too short");
  property p_ge; $changed(enable_pin) |=> $stable(enable_pin) [*5]; endproperty
  a_ge: assert property (p_ge) else $error("enable pulse too short");
endmodule : gate_driver_host_chk
bind gate_driver_host gate_driver_host_chk #(.FAULT_MUTE_CYC(FAULT_MUTE_CYC),
  .RESET_FILTER_CYC(RESET_FILTER_CYC)) chk (.clk(clk), .resetn(resetn),
  .invert_mode(invert_mode), .pwm_noninv_pin(pwm_noninv_pin), .pwm_inv_pin(pwm_inv_pin),
  .enable_pin(enable_pin), .fault_flag_n(fault_flag_n), .fault_seen(fault_seen),
  .running(running), .supply_good_pin(supply_good_pin), .supply_good(supply_good));
`default_nettype wire

// ### dv/gate_driver_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gate_driver_host_tb;
  logic clk = 1'b0, resetn = 1'b0, run_req = 1'b0, pwm_cmd = 1'b0, pwm_low_cmd = 1'b0;
  logic auto_reset_mode = 1'b0, invert_mode = 1'b0, fault_clear_req = 1'b0;
  logic oc = 1'b0, uvlo = 1'b0;
  logic [6:0] duty = 7'h0A;
  logic running, fault_seen, supply_good, sense_valid, gate_on;
  logic pwm_noninv_pin, pwm_inv_pin, enable_pin, fault_flag_n, supply_good_pin, sense_pwm_out;
  logic [15:0] sense_period, sense_high;
  int error_cnt = 0;
  int checks = 0;
  // Short mute and filter keep the fault walk brief.
  gate_driver_host #(.FAULT_MUTE_CYC(16'h0004), .RESET_FILTER_CYC(16'h0006)) dut (
    .clk(clk), .resetn(resetn), .run_req(run_req), .pwm_cmd(pwm_cmd),
    .pwm_low_cmd(pwm_low_cmd), .auto_reset_mode(auto_reset_mode), .invert_mode(invert_mode),
    .fault_clear_req(fault_clear_req), .running(running), .fault_seen(fault_seen),
    .supply_good(supply_good), .sense_period(sense_period), .sense_high(sense_high),
    .sense_valid(sense_valid), .pwm_noninv_pin(pwm_noninv_pin), .pwm_inv_pin(pwm_inv_pin),
    .enable_pin(enable_pin), .fault_flag_n(fault_flag_n), .supply_good_pin(supply_good_pin),
    .sense_pwm_out(sense_pwm_out));
  gate_driver_model drv (.clk(clk), .in_p(pwm_noninv_pin), .in_n(pwm_inv_pin),
    .en(enable_pin), .overcurrent_sense(oc), .uvlo(uvlo), .duty(duty), .gate_on(gate_on),
    .fault_flag_n(fault_flag_n), .supply_good_pin(supply_good_pin),
    .sense_pwm_out(sense_pwm_out));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask : cmp
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  // Start up, drive the gate on, then command both driver inputs high and check noninv drops.
  task automatic t_run;
    cmp({15'h0, gate_on}, 16'h0000, "gate after reset");
    run_req = 1'b1;
    pwm_cmd = 1'b1;
    for (int i = 0; i < 100 && running !== 1'b1; i++) @(negedge clk);
    idle(30);
    cmp({15'h0, gate_on}, 16'h0001, "gate on");
    cmp({15'h0, running}, 16'h0001, "running");
    pwm_low_cmd = 1'b1;
    idle(20);
    cmp({15'h0, gate_on}, 16'h0000, "interlock");
    cmp({15'h0, pwm_noninv_pin}, 16'h0000, "noninv dropped");
    pwm_low_cmd = 1'b0;
    idle(30);
  endtask : t_run
  // Trip a fault, hold without a clear request, then clear it.
  task automatic t_fault;
    oc = 1'b1;
    for (int i = 0; i < 100 && fault_seen !== 1'b1; i++) @(negedge clk);
    cmp({15'h0, fault_seen}, 16'h0001, "fault seen");
    cmp({15'h0, gate_on}, 16'h0000, "gate off");
    cmp({15'h0, running}, 16'h0000, "stopped on fault");
    oc = 1'b0;
    idle(40);
    cmp({15'h0, fault_flag_n}, 16'h0000, "flag latched");
    fault_clear_req = 1'b1;
    for (int i = 0; i < 300 && running !== 1'b1; i++) @(negedge clk);
    idle(30);
    cmp({15'h0, fault_flag_n}, 16'h0001, "flag released");
    cmp({15'h0, fault_seen}, 16'h0000, "fault cleared");
    cmp({15'h0, gate_on}, 16'h0001, "gate resumed");
    cmp({15'h0, running}, 16'h0001, "running again");
    fault_clear_req = 1'b0;
  endtask : t_fault
  // Supply loss and return.
  task automatic t_uv;
    uvlo = 1'b1;
    idle(10);
    cmp({15'h0, supply_good}, 16'h0000, "supply lost");
    cmp({15'h0, gate_on}, 16'h0000, "gate in lockout");
    uvlo = 1'b0;
    idle(60);
    cmp({15'h0, supply_good}, 16'h0001, "supply back");
    cmp({15'h0, gate_on}, 16'h0001, "gate after lockout");
  endtask : t_uv
  // Sense duty at both ends and the middle of its range.
  task automatic t_sense;
    logic [6:0] dl[3] = '{7'h0A, 7'h32, 7'h58};
    int n;
    foreach (dl[k]) begin
      duty = dl[k];
      n = 0;
      for (int i = 0; i < 400 && n < 2; i++) begin
        @(negedge clk);
        if (sense_valid === 1'b1) n++;
      end
      cmp(16'(n), 16'h0002, "sense results");
      cmp(sense_high, {9'h000, dl[k]}, "sense high");
      cmp(sense_period, 16'h0064, "sense period");
    end
  endtask : t_sense
  // Inverting drive with the enable line following the inverse of the pulse.
  task automatic t_inv;
    pwm_cmd = 1'b0;
    invert_mode = 1'b1;
    auto_reset_mode = 1'b1;
    for (int k = 0; k < 2; k++) begin
      idle(40);
      cmp({15'h0, pwm_noninv_pin}, 16'h0001, "noninv held");
      cmp({15'h0, enable_pin}, {15'h0, !pwm_inv_pin}, "enable inverse");
      cmp({15'h0, gate_on}, {15'h0, pwm_cmd}, "gate follows");
      pwm_cmd = 1'b1;
    end
  endtask : t_inv
  task automatic report_and_stop;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  initial begin
    idle(3);
    resetn = 1'b1;
    idle(4);
    t_run();
    t_fault();
    t_uv();
    t_sense();
    t_inv();
    report_and_stop();
  end
  // The tests need at most about 2000 cycles; a hang is cut off well beyond that.
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
endmodule : gate_driver_host_tb
`default_nettype wire
